// file: design/sbrg_pkg.sv
/*
  Package for the serial baud tick generator: widths, reset values and
  period multiplier codes.
  Assumes a single system clock domain; nothing here holds state.
*/
package sbrg_pkg;
  localparam int unsigned DIV_W = 16;
  localparam int unsigned LOW_W = 8;
  localparam int unsigned PRE_W = 6;
  localparam logic [15:0] DIVISOR_RST = 16'h0000;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [5:0] PRESCALE_RST = 6'h00;
  // Prescale terminal counts (period minus one) in system clocks
  localparam logic [5:0] PRE_DIV64 = 6'h3f;
  localparam logic [5:0] PRE_DIV16 = 6'h0f;
  localparam logic [5:0] PRE_DIV4 = 6'h03;
  localparam logic [5:0] PRE_DIV1 = 6'h00;

  // Period multiplier selection
  typedef enum logic [1:0] {
    SBRG_MUL64,
    SBRG_MUL16,
    SBRG_MUL4
  } sbrg_mul_e;
endpackage : sbrg_pkg

// file: design/sbrg_prescaler.sv
/*
  Prescaler for the baud tick generator: divides the system clock by the
  selected multiplier and pulses a strobe once per prescaled period.
  Assumes i_sys_clk and asynchronous active-low i_rstn.
*/
module sbrg_prescaler (
  input wire logic i_sys_clk, // System clock
  input wire logic i_rstn, // Async reset, active low
  input wire logic i_clear, // Restart prescale count
  input wire logic [5:0] i_last, // Terminal count
  output logic o_strobe // One prescaled period elapsed
);
  typedef struct packed {
    logic [5:0] cnt;
    logic strobe;
  } sbrg_pre_s;

  sbrg_pre_s st_r;
  sbrg_pre_s st_nxt;

  // Count to terminal, wrap, strobe
  always_comb begin
    st_nxt = st_r;
    st_nxt.strobe = 1'b0;
    if (i_clear) begin
      st_nxt.cnt = sbrg_pkg::PRESCALE_RST;
    end else if (st_r.cnt >= i_last) begin
      st_nxt.cnt = sbrg_pkg::PRESCALE_RST;
      st_nxt.strobe = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 6'h01;
    end
  end

  // State register
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_strobe = st_r.strobe;
endmodule : sbrg_prescaler

// file: design/sbrg_baud_tick_generator.sv
/*
  Free-running baud tick generator for the serial port transmit and
  receive shift logic. Emits a one-cycle tick every bit period.
  Assumes one system clock, asynchronous active-low reset, and that
  control inputs and divisor write strobes are synchronous to the clock.
*/
//
// Contract
// - Counter is 8-bit after reset; 16-bit only while wide select is set.
// - Timer runs continuously; period comes from divisor low byte, or high:low bytes while wide select is set.
// - Asynchronous mode: multiplier chosen by high-speed and wide selects together.
// - Synchronous mode: high-speed select has no effect on the period.
// - Any divisor byte write clears the timer at once.
// - Async 8-bit low-speed rate is clock over 64 times divisor plus one.
module sbrg_baud_tick_generator (
  input wire logic i_sys_clk, // System clock, 40 MHz
  input wire logic i_rstn, // Async reset, active low
  input wire logic i_wide_counter_select, // 16-bit counter when high
  input wire logic i_high_speed_select, // High-speed multiplier
  input wire logic i_sync_mode, // Synchronous operation
  input wire logic i_divisor_low_we, // Write strobe, low byte
  input wire logic i_divisor_high_we, // Write strobe, high byte
  input wire logic [7:0] i_divisor_wdata, // Divisor write data
  output logic [7:0] o_divisor_low_byte, // Low byte readback
  output logic [7:0] o_divisor_high_byte, // High byte readback
  output logic [15:0] o_count, // Current timer count
  output logic o_baud_tick // One-cycle tick per bit period
);
  typedef struct packed {
    logic [7:0] div_lo;
    logic [7:0] div_hi;
    logic [15:0] count;
    logic tick;
  } sbrg_state_s;

  sbrg_state_s st_r;
  sbrg_state_s st_nxt;
  logic pre_strobe;
  logic div_write;
  logic [5:0] pre_last;
  logic [15:0] reload;

  // Map a multiplier code onto a prescale terminal count
  function automatic logic [5:0] sbrg_mul_last(input sbrg_pkg::sbrg_mul_e mul);
    case (mul)
      sbrg_pkg::SBRG_MUL64: sbrg_mul_last = sbrg_pkg::PRE_DIV64;
      sbrg_pkg::SBRG_MUL16: sbrg_mul_last = sbrg_pkg::PRE_DIV16;
      default: sbrg_mul_last = sbrg_pkg::PRE_DIV4;
    endcase
  endfunction : sbrg_mul_last

  // Multiplier selection per mode and width
  always_comb begin
    if (i_sync_mode) begin
      pre_last = sbrg_mul_last(sbrg_pkg::SBRG_MUL4);
    end else if (i_high_speed_select && i_wide_counter_select) begin
      pre_last = sbrg_mul_last(sbrg_pkg::SBRG_MUL4);
    end else if (i_high_speed_select || i_wide_counter_select) begin
      pre_last = sbrg_mul_last(sbrg_pkg::SBRG_MUL16);
    end else begin
      pre_last = sbrg_mul_last(sbrg_pkg::SBRG_MUL64);
    end
  end

  // Either divisor byte written
  assign div_write = i_divisor_low_we | i_divisor_high_we;

  // Reload value per counter width
  assign reload = i_wide_counter_select ? {st_r.div_hi, st_r.div_lo}
                                        : {8'h00, st_r.div_lo};

  sbrg_prescaler u_prescaler (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_clear(div_write),
    .i_last(pre_last),
    .o_strobe(pre_strobe)
  );

  // Divisor storage and up counter
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (i_divisor_low_we) begin
      st_nxt.div_lo = i_divisor_wdata;
    end
    if (i_divisor_high_we) begin
      st_nxt.div_hi = i_divisor_wdata;
    end
    if (div_write) begin
      st_nxt.count = sbrg_pkg::COUNT_RST;
    end else if (pre_strobe) begin
      if (st_r.count >= reload) begin
        st_nxt.count = sbrg_pkg::COUNT_RST;
        st_nxt.tick = 1'b1;
      end else begin
        st_nxt.count = st_r.count + 16'h0001;
      end
    end
  end

  // State register
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r.div_lo <= sbrg_pkg::DIVISOR_RST[7:0];
      st_r.div_hi <= sbrg_pkg::DIVISOR_RST[15:8];
      st_r.count <= sbrg_pkg::COUNT_RST;
      st_r.tick <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign o_divisor_low_byte = st_r.div_lo;
  assign o_divisor_high_byte = st_r.div_hi;
  assign o_count = st_r.count;
  assign o_baud_tick = st_r.tick;
endmodule : sbrg_baud_tick_generator

// file: sim/sbrg_assertions.sv
/* Checker for the baud tick generator.
   Bound to the top module; sees its ports only. */
module sbrg_chk (
  input wire logic i_sys_clk, i_rstn, i_wide_counter_select, i_high_speed_select, // Ctl
  input wire logic i_sync_mode, i_divisor_low_we, i_divisor_high_we, // Mode, strobes
  input wire logic [7:0] i_divisor_wdata, o_divisor_low_byte, o_divisor_high_byte, // Bytes
  input wire logic [15:0] o_count, // Timer count
  input wire logic o_baud_tick // Tick
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [22:0] cnt_r, per;
  logic [2:0] md_r;
  logic ok_r;
  wire we = i_divisor_low_we | i_divisor_high_we;
  wire [2:0] md = {i_sync_mode, i_high_speed_select, i_wide_counter_select};
  wire [15:0] d = md[0] ? {o_divisor_high_byte, o_divisor_low_byte} : {8'h00, o_divisor_low_byte};
  // Expected period: multiplier times divisor plus one
  always_comb begin
    per = (md[2] || md[1:0] == 2'h3) ? 23'h4 : (md[1] || md[0]) ? 23'h10 : 23'h40;
    per = per * (23'(d) + 23'h1);
  end
  // Cycles since last tick; trusted only after a tick with nothing changed
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_r <= 23'h0;
      ok_r <= 1'b0;
      md_r <= 3'h0;
    end else begin
      md_r <= md;
      cnt_r <= o_baud_tick ? 23'h1 : cnt_r + 23'h1;
      ok_r <= (o_baud_tick | ok_r) & ~we & (md == md_r);
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_low_wr; i_divisor_low_we ##1 1'b1; endsequence
  property p_low_rb; s_low_wr |-> o_divisor_low_byte == $past(i_divisor_wdata); endproperty
  a_low_rb: assert property (p_low_rb) else $error("low byte not stored");
  property p_high_rb; i_divisor_high_we |=> o_divisor_high_byte == $past(i_divisor_wdata); endproperty
  a_high_rb: assert property (p_high_rb) else $error("high byte not stored");
  property p_clear; we |=> o_count == 16'h0000; endproperty
  a_clear: assert property (p_clear) else $error("write did not clear timer");
  property p_pulse; o_baud_tick |=> !o_baud_tick; endproperty
  a_pulse: assert property (p_pulse) else $error("tick wider than one cycle");
  property p_period; ok_r && (md == md_r) && o_baud_tick |-> cnt_r == per; endproperty
  a_period: assert property (p_period) else $error("wrong tick period");
  property p_on_time; ok_r && (md == md_r) |-> cnt_r <= per; endproperty
  a_on_time: assert property (p_on_time) else $error("tick missing");
  property p_limit; ok_r && (md == md_r) |-> o_count <= d; endproperty
  a_limit: assert property (p_limit) else $error("count past divisor");
endmodule : sbrg_chk
bind sbrg_baud_tick_generator sbrg_chk chk_u (.*);

// file: sim/sbrg_partner.sv
/* Shift logic model: consumes ticks, reports the last gap.
   Assumes the generator's clock and reset. */
module sbrg_partner (
  input wire logic i_sys_clk, // Clock
  input wire logic i_rstn, // Reset, active low
  input wire logic i_baud_tick, // Tick in
  output logic [22:0] o_gap // Cycles between last two ticks
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [22:0] run_r;
  // Clock never changes under it, so receive stays safe
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      run_r <= 23'h1;
      o_gap <= 23'h0;
    end else begin
      run_r <= i_baud_tick ? 23'h1 : run_r + 23'h1;
      if (i_baud_tick) o_gap <= run_r;
    end
  end
endmodule : sbrg_partner

// file: sim/sbrg_baud_tick_generator_tb.sv
/* Bench for the baud tick generator.
   Drives at the falling edge; partner measures tick gaps. */
module sbrg_baud_tick_generator_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rstn = 1'b0, wide = 1'b0, hs = 1'b0, sync = 1'b0, lwe = 1'b0, hwe = 1'b0;
  logic tick;
  logic [7:0] wd = 8'h00;
  logic [7:0] lo, hi;
  logic [22:0] gap;
  int n_mismatch = 0, n_compared = 0, wt;
  sbrg_baud_tick_generator dut_u (.i_sys_clk(clk), .i_rstn(rstn), .i_wide_counter_select(wide),
    .i_high_speed_select(hs), .i_sync_mode(sync), .i_divisor_low_we(lwe),
    .i_divisor_high_we(hwe), .i_divisor_wdata(wd), .o_divisor_low_byte(lo),
    .o_divisor_high_byte(hi), .o_count(), .o_baud_tick(tick));
  sbrg_partner part_u (.i_sys_clk(clk), .i_rstn(rstn), .i_baud_tick(tick), .o_gap(gap));
  initial forever #12.5 clk = ~clk;
  task chk(input logic [22:0] got, input logic [22:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic hi, input logic [7:0] v);
    @(negedge clk); {hwe, lwe, wd} = {hi, !hi, v};
    @(negedge clk); {hwe, lwe} = 2'h0;
  endtask : wr
  task ticks(input int n);
    repeat (n) begin
      wt = 0;
      do begin @(negedge clk); wt++; end while (tick !== 1'b1 && wt < 20000);
    end
    @(negedge clk); // Let the partner record the gap of the last tick
  endtask : ticks
  // Every async multiplier, with the high byte only used in wide mode
  task t_async;
    wr(1'b1, 8'h01);
    wr(1'b0, 8'h03);
    chk({15'h0, hi}, 23'h01);
    chk({15'h0, lo}, 23'h03);
    for (int i = 0; i < 4; i++) begin
      {hs, wide} = 2'(i);
      ticks(3);
      chk(gap, ((i == 0) ? 23'h40 : (i == 3) ? 23'h4 : 23'h10) * (wide ? 23'h104 : 23'h4));
    end
  endtask : t_async
  // Sync mode ignores the high-speed select
  task t_sync;
    {sync, wide} = 2'h2;
    for (int i = 0; i < 2; i++) begin
      hs = i[0];
      ticks(3);
      chk(gap, 23'h10);
    end
  endtask : t_sync
  // Mid-count rewrite restarts with the short period at once
  task t_restart;
    {sync, hs, wide} = 3'h0;
    wr(1'b0, 8'hc8);
    ticks(1);
    repeat (100) @(negedge clk);
    wr(1'b0, 8'h00);
    ticks(1);
    chk({22'h0, wt < 72}, 23'h1);
  endtask : t_restart
  task give_verdict;
    if (n_mismatch == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  initial begin
    #2000000 n_mismatch++;
    give_verdict;
  end
  initial begin
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    t_async;
    t_sync;
    t_restart;
    give_verdict;
  end
endmodule : sbrg_baud_tick_generator_tb
